// ===== design/cwd_pkg.sv
package cwd_pkg;

  // Width and location of the configuration word in the programming address space.
  localparam int CWD_WORD_W = 14;
  localparam int CWD_ADDR_W = 14;
  localparam logic [13:0] CWD_CFG_ADDR = 14'h2007;
  localparam logic [13:0] CWD_CFG_BASE = 14'h2000;
  localparam logic [13:0] CWD_ERASED = 14'h3FFF;

  // Programming commands, six bits, sent least significant bit first by the programmer.
  localparam logic [5:0] CWD_CMD_LOAD_CFG = 6'h00;
  localparam logic [5:0] CWD_CMD_LOAD_DATA = 6'h02;
  localparam logic [5:0] CWD_CMD_READ_DATA = 6'h04;
  localparam logic [5:0] CWD_CMD_INCR_ADDR = 6'h06;
  localparam logic [5:0] CWD_CMD_BEGIN_PROG = 6'h08;
  localparam logic [5:0] CWD_CMD_END_PROG = 6'h0E;

  // Field positions.
  localparam int CWD_OSC_LSB = 0;
  localparam int CWD_WATCHDOG_BIT = 2;
  localparam int CWD_PUT_BIT = 3;
  localparam int CWD_LOCK_LO_LSB = 4;
  localparam int CWD_BROWNOUT_BIT = 6;
  localparam int CWD_LOCK_MID_LSB = 8;
  localparam int CWD_TRIP_LSB = 10;
  localparam int CWD_LOCK_HI_LSB = 12;

  // Bits that read back as one because a layout leaves them unimplemented.
  localparam logic [13:0] CWD_UNIMPL_EARLY = 14'h3FE0;
  localparam logic [13:0] CWD_UNIMPL_PLAIN = 14'h3FC0;
  localparam logic [13:0] CWD_UNIMPL_REPL = 14'h0080;
  localparam logic [13:0] CWD_UNIMPL_NONE = 14'h0000;
  localparam logic [13:0] CWD_UNIMPL_NOBOR = 14'h00C0;
  localparam logic [13:0] CWD_UNIMPL_LOWEND = 14'h3F80;

  // Single-bit protection layout: copies in 13-7 and 5-4, low block stays writable.
  localparam logic [13:0] CWD_SINGLE_MASK = 14'h3FB0;
  localparam logic [13:0] CWD_SINGLE_WR_LO = 14'h0000;
  localparam logic [13:0] CWD_SINGLE_WR_HI = 14'h003F;

  // Address aliasing on the smaller low-end-protection member.
  localparam logic [13:0] CWD_ALIAS_LO = 14'h1000;
  localparam logic [13:0] CWD_ALIAS_HI = 14'h1FFF;
  localparam logic [13:0] CWD_ALIAS_MASK = 14'h0FFF;

  typedef enum logic [10:0] {
    CWD_LAY_EARLY = 11'h001,   // single protect bit at bit 4, no brown-out
    CWD_LAY_PLAIN = 11'h002,   // two-bit protect at 5-4, no brown-out
    CWD_LAY_STD = 11'h004,     // replicated protect, brown-out at bit 6
    CWD_LAY_MID = 11'h008,
    CWD_LAY_SMALL = 11'h010,
    CWD_LAY_SINGLE = 11'h020,
    CWD_LAY_VTH = 11'h040,
    CWD_LAY_PLL = 11'h080,
    CWD_LAY_NOBOR = 11'h100,
    CWD_LAY_LOWEND = 11'h200,
    CWD_LAY_LOWEND_SM = 11'h400
  } cwd_layout_t;

  typedef enum logic [5:0] {
    CWD_PROT_NONE = 6'h01,
    CWD_PROT_UPPER_HALF = 6'h02,
    CWD_PROT_UPPER_3Q = 6'h04,
    CWD_PROT_ALL = 6'h08,
    CWD_PROT_LOWER_HALF = 6'h10,
    CWD_PROT_ALL_BUT_256 = 6'h20
  } cwd_protect_t;

  typedef enum logic [7:0] {
    CWD_OSC_RC = 8'h01,
    CWD_OSC_HS = 8'h02,
    CWD_OSC_XT = 8'h04,
    CWD_OSC_LP = 8'h08,
    CWD_OSC_EXT_PLL = 8'h10,
    CWD_OSC_HS_PLL = 8'h20,
    CWD_OSC_EXT_CLK_OUT = 8'h40,
    CWD_OSC_HS_NOPLL = 8'h80
  } cwd_osc_t;

  typedef enum logic [3:0] {
    CWD_TRIP_2V5 = 4'h1,
    CWD_TRIP_2V7 = 4'h2,
    CWD_TRIP_4V2 = 4'h4,
    CWD_TRIP_4V5 = 4'h8
  } cwd_trip_t;

  // Programmer command as it arrives after deserialisation.
  typedef struct packed {
    logic valid;
    logic [5:0] code;
    logic [13:0] data;
  } cwd_cmd_t;

  // Decoded device settings.
  typedef struct packed {
    cwd_protect_t protect;
    logic copies_agree;
    logic low_block_writable;
    logic brownout_reset_enable;
    cwd_trip_t brownout_trip_voltage;
    logic powerup_timer_on;
    logic watchdog_enable;
    cwd_osc_t oscillator_select;
  } cwd_settings_t;

endpackage : cwd_pkg

// ===== design/cwd_decoder.sv
// Functional notes
// - Standard protect codes: off, half, three quarters, all.
// - Mid layout: 1x off, 01 half, 00 all.
// - Smallest layout: only 00 protects everything.
// - Protection applies only when all copies agree.
// - Unimplemented word bits read back as one.
// - Bit 6 set enables brown-out reset.
// - Bit 3 low enables the power-up timer.
// - Brown-out enable forces the power-up timer on.
// - Bit 2 set enables the watchdog.
// - Oscillator codes: RC, HS, XT, LP.
// - PLL layout oscillator codes differ.
// - Single protect bit replicated; low block writable.
// - Threshold layout: bits 11-10 select brown-out trip voltage.
// - Low-end layout protects from the bottom.
// - Smaller low-end member aliases upper addresses down.
// - Fourteen-bit word lives at 2007h.
// - Programmed bit reads zero, erased reads one.
// - Load configuration sets address counter to 2000h.
`timescale 1ns/100ps
`default_nettype none

module cwd_decoder
  import cwd_pkg::*;
#(
  parameter cwd_layout_t LAYOUT = CWD_LAY_STD, // Word layout of this device.
  parameter logic [13:0] INIT_WORD = CWD_ERASED // Word content restored at reset.
) (
  input wire logic clk, // 10 MHz clock.
  input wire logic resetn, // Synchronous reset, active low.
  input wire cwd_cmd_t cmd, // Deserialised programmer command.
  input wire logic [13:0] prog_addr_in, // Program address from the core fetch side.
  output logic [13:0] read_data, // Data returned for a read command.
  output logic read_valid, // Read data valid, one-cycle pulse.
  output logic [13:0] addr_counter, // Programming address counter.
  output logic programming, // Programming pulse in progress.
  output logic [13:0] config_word, // Configuration word as read back.
  output logic [13:0] prog_addr_mapped, // Program address after aliasing.
  output cwd_settings_t settings // Decoded device settings.
);

  // A command counts only on the edge where its strobe is high.
  function automatic logic cmd_is(input cwd_cmd_t c, input logic [5:0] code);
    cmd_is = c.valid && (c.code == code);
  endfunction : cmd_is

  function automatic logic [13:0] unimpl_mask(input cwd_layout_t lay);
    unique case (lay)
      CWD_LAY_EARLY: unimpl_mask = CWD_UNIMPL_EARLY;
      CWD_LAY_PLAIN: unimpl_mask = CWD_UNIMPL_PLAIN;
      CWD_LAY_STD, CWD_LAY_MID, CWD_LAY_SMALL: unimpl_mask = CWD_UNIMPL_REPL;
      CWD_LAY_SINGLE: unimpl_mask = CWD_UNIMPL_NONE;
      CWD_LAY_VTH: unimpl_mask = CWD_UNIMPL_REPL;
      CWD_LAY_PLL, CWD_LAY_NOBOR: unimpl_mask = CWD_UNIMPL_NOBOR;
      CWD_LAY_LOWEND, CWD_LAY_LOWEND_SM: unimpl_mask = CWD_UNIMPL_LOWEND;
      default: unimpl_mask = CWD_UNIMPL_NONE;
    endcase
  endfunction : unimpl_mask

  // Layouts without a brown-out cell must never report it enabled, whatever bit 6 holds.
  function automatic logic has_brownout(input cwd_layout_t lay);
    has_brownout = (lay == CWD_LAY_STD) || (lay == CWD_LAY_MID) || (lay == CWD_LAY_SMALL) ||
                   (lay == CWD_LAY_SINGLE) || (lay == CWD_LAY_VTH) || (lay == CWD_LAY_LOWEND) ||
                   (lay == CWD_LAY_LOWEND_SM);
  endfunction : has_brownout

  function automatic logic [1:0] pair_at(input logic [13:0] w, input int lsb);
    pair_at = w[lsb +: 2];
  endfunction : pair_at

  logic [13:0] word_r;
  logic [13:0] word_nxt;
  logic [13:0] latch_r;
  logic [13:0] addr_r;
  logic prog_r;
  logic [13:0] rdata_r;
  logic rvalid_r;
  logic [13:0] mapped_r;
  cwd_settings_t set_r;
  cwd_settings_t set_nxt;
  logic [13:0] word_view;
  logic is_cfg;

  // Unimplemented cells are forced high so the programmer never sees stray zeros.
  assign word_view = word_r | unimpl_mask(LAYOUT);
  assign is_cfg = (addr_r == CWD_CFG_ADDR);

  // Address counter, loaded by load configuration and stepped by increment.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      addr_r <= 14'h0000;
    end else if (cmd.valid) begin
      if (cmd.code == CWD_CMD_LOAD_CFG) begin
        addr_r <= CWD_CFG_BASE;
      end else if (cmd.code == CWD_CMD_INCR_ADDR) begin
        addr_r <= addr_r + 14'h0001;
      end
    end
  end

  // The data latch is filled by both load commands; loading configuration also moves the counter.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      latch_r <= CWD_ERASED;
    end else if (cmd_is(cmd, CWD_CMD_LOAD_CFG) || cmd_is(cmd, CWD_CMD_LOAD_DATA)) begin
      latch_r <= cmd.data;
    end
  end

  // The pulse length is left wholly to the programmer; no timer bounds it here.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      prog_r <= 1'b0;
    end else if (cmd_is(cmd, CWD_CMD_BEGIN_PROG)) begin
      prog_r <= 1'b1;
    end else if (cmd_is(cmd, CWD_CMD_END_PROG)) begin
      prog_r <= 1'b0;
    end
  end

  // One-time cells can only be driven from erased to programmed, so each pulse ANDs the latch in.
  always_comb begin
    word_nxt = word_r;
    if (prog_r && is_cfg) begin
      word_nxt = word_r & latch_r;
    end
  end

  // The word is modelled as nonvolatile content restored to a fixed image at reset.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      word_r <= INIT_WORD;
    end else begin
      word_r <= word_nxt;
    end
  end

  // Read answers one cycle after the command; only the configuration word lives here.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdata_r <= CWD_ERASED;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= cmd_is(cmd, CWD_CMD_READ_DATA);
      if (cmd_is(cmd, CWD_CMD_READ_DATA)) begin
        rdata_r <= is_cfg ? word_view : CWD_ERASED;
      end
    end
  end

  // Address aliasing for the smaller low-end member.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mapped_r <= 14'h0000;
    end else if ((LAYOUT == CWD_LAY_LOWEND_SM) && (prog_addr_in >= CWD_ALIAS_LO) &&
                 (prog_addr_in <= CWD_ALIAS_HI)) begin
      mapped_r <= prog_addr_in & CWD_ALIAS_MASK;
    end else begin
      mapped_r <= prog_addr_in;
    end
  end

  // Single-bit protection: a programmed bit protects everything.
  function automatic cwd_protect_t single_protect(input logic bit_val);
    single_protect = bit_val ? CWD_PROT_NONE : CWD_PROT_ALL;
  endfunction : single_protect

  // Setting decode; the layout is fixed at elaboration.
  always_comb begin
    logic [1:0] lock_lo;
    logic [1:0] osc;
    logic agree;
    lock_lo = pair_at(word_view, CWD_LOCK_LO_LSB);
    osc = pair_at(word_view, CWD_OSC_LSB);
    agree = 1'b1;
    set_nxt.protect = CWD_PROT_NONE;
    set_nxt.low_block_writable = 1'b0;
    set_nxt.brownout_trip_voltage = CWD_TRIP_2V5;
    set_nxt.oscillator_select = CWD_OSC_RC;

    // Copy checking for each replicated layout.
    unique case (LAYOUT)
      CWD_LAY_STD, CWD_LAY_MID, CWD_LAY_SMALL, CWD_LAY_PLL, CWD_LAY_NOBOR: begin
        // The third copy sits where the threshold layout keeps its trip field.
        agree = (pair_at(word_view, CWD_LOCK_MID_LSB) == lock_lo) &&
                (pair_at(word_view, CWD_LOCK_HI_LSB) == lock_lo) &&
                (pair_at(word_view, CWD_TRIP_LSB) == lock_lo);
      end
      CWD_LAY_VTH: begin
        agree = (pair_at(word_view, CWD_LOCK_MID_LSB) == lock_lo) &&
                (pair_at(word_view, CWD_LOCK_HI_LSB) == lock_lo);
      end
      CWD_LAY_SINGLE: begin
        agree = ((word_view & CWD_SINGLE_MASK) == CWD_SINGLE_MASK) ||
                ((word_view & CWD_SINGLE_MASK) == 14'h0000);
      end
      default: agree = 1'b1;
    endcase
    set_nxt.copies_agree = agree;

    // A disagreeing set of copies leaves memory unprotected.
    if (agree) begin
      unique case (LAYOUT)
        CWD_LAY_EARLY: begin
          set_nxt.protect = single_protect(word_view[CWD_LOCK_LO_LSB]);
        end
        CWD_LAY_SINGLE: begin
          set_nxt.protect = single_protect(word_view[CWD_LOCK_LO_LSB]);
          set_nxt.low_block_writable = !word_view[CWD_LOCK_LO_LSB];
        end
        CWD_LAY_MID: begin
          unique case (lock_lo)
            2'b11: set_nxt.protect = CWD_PROT_NONE;
            2'b10: set_nxt.protect = CWD_PROT_NONE;
            2'b01: set_nxt.protect = CWD_PROT_UPPER_HALF;
            2'b00: set_nxt.protect = CWD_PROT_ALL;
          endcase
        end
        CWD_LAY_SMALL: begin
          unique case (lock_lo)
            2'b11: set_nxt.protect = CWD_PROT_NONE;
            2'b10: set_nxt.protect = CWD_PROT_NONE;
            2'b01: set_nxt.protect = CWD_PROT_NONE;
            2'b00: set_nxt.protect = CWD_PROT_ALL;
          endcase
        end
        CWD_LAY_LOWEND, CWD_LAY_LOWEND_SM: begin
          unique case (lock_lo)
            2'b11: set_nxt.protect = CWD_PROT_NONE;
            2'b10: set_nxt.protect = CWD_PROT_LOWER_HALF;
            2'b01: set_nxt.protect = CWD_PROT_ALL_BUT_256;
            2'b00: set_nxt.protect = CWD_PROT_ALL;
          endcase
        end
        default: begin
          unique case (lock_lo)
            2'b11: set_nxt.protect = CWD_PROT_NONE;
            2'b10: set_nxt.protect = CWD_PROT_UPPER_HALF;
            2'b01: set_nxt.protect = CWD_PROT_UPPER_3Q;
            2'b00: set_nxt.protect = CWD_PROT_ALL;
          endcase
        end
      endcase
    end

    set_nxt.brownout_reset_enable = has_brownout(LAYOUT) && word_view[CWD_BROWNOUT_BIT];
    if (LAYOUT == CWD_LAY_VTH) begin
      unique case (pair_at(word_view, CWD_TRIP_LSB))
        2'b11: set_nxt.brownout_trip_voltage = CWD_TRIP_2V5;
        2'b10: set_nxt.brownout_trip_voltage = CWD_TRIP_2V7;
        2'b01: set_nxt.brownout_trip_voltage = CWD_TRIP_4V2;
        2'b00: set_nxt.brownout_trip_voltage = CWD_TRIP_4V5;
      endcase
    end
    // Brown-out recovery needs the timer, so it overrides the enable bit.
    set_nxt.powerup_timer_on = !word_view[CWD_PUT_BIT] || set_nxt.brownout_reset_enable;
    set_nxt.watchdog_enable = word_view[CWD_WATCHDOG_BIT];

    if (LAYOUT == CWD_LAY_PLL) begin
      unique case (osc)
        2'b11: set_nxt.oscillator_select = CWD_OSC_EXT_PLL;
        2'b10: set_nxt.oscillator_select = CWD_OSC_HS_PLL;
        2'b01: set_nxt.oscillator_select = CWD_OSC_EXT_CLK_OUT;
        2'b00: set_nxt.oscillator_select = CWD_OSC_HS_NOPLL;
      endcase
    end else begin
      unique case (osc)
        2'b11: set_nxt.oscillator_select = CWD_OSC_RC;
        2'b10: set_nxt.oscillator_select = CWD_OSC_HS;
        2'b01: set_nxt.oscillator_select = CWD_OSC_XT;
        2'b00: set_nxt.oscillator_select = CWD_OSC_LP;
      endcase
    end
  end

  // Settings are registered so that a word being programmed never glitches the decoded outputs.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      set_r.protect <= CWD_PROT_NONE;
      set_r.copies_agree <= 1'b1;
      set_r.low_block_writable <= 1'b0;
      set_r.brownout_reset_enable <= 1'b0;
      set_r.brownout_trip_voltage <= CWD_TRIP_2V5;
      set_r.powerup_timer_on <= 1'b0;
      set_r.watchdog_enable <= 1'b0;
      set_r.oscillator_select <= CWD_OSC_RC;
    end else begin
      set_r <= set_nxt;
    end
  end

  assign read_data = rdata_r;
  assign read_valid = rvalid_r;
  assign addr_counter = addr_r;
  assign programming = prog_r;
  assign config_word = word_view;
  assign prog_addr_mapped = mapped_r;
  assign settings = set_r;

endmodule : cwd_decoder

`default_nettype wire

// ===== tb/cwd_prog_model.sv
`timescale 1ns/100ps
`default_nettype none

module cwd_prog_model
  import cwd_pkg::*;
(
  input wire logic clk, // Device clock.
  output cwd_cmd_t cmd // Deserialised command toward the device.
);
  initial begin
    cmd = '{valid: 1'b0, code: 6'h3F, data: 14'h0000};
  end

  task automatic send(input logic [5:0] code, input logic [13:0] data);
    cmd = '{valid: 1'b1, code: code, data: data};
    @(posedge clk);
    #10;
  endtask : send

  // Released lines show an inverted pattern so that stale values never look fresh.
  task automatic idle(input int n);
    for (int k = 0; k < n; k++) begin
      cmd = '{valid: 1'b0, code: ~cmd.code, data: ~cmd.data};
      @(posedge clk);
      #10;
    end
  endtask : idle

  // The word arrives whole from the caller's image, copies included, so a mismatch is only sent on purpose.
  task automatic program_word(input logic [13:0] d);
    send(CWD_CMD_LOAD_CFG, d);
    for (int k = 0; k < 7; k++) begin
      send(CWD_CMD_INCR_ADDR, 14'h0000);
    end
    send(CWD_CMD_BEGIN_PROG, 14'h0000);
    idle(2);
    send(CWD_CMD_END_PROG, 14'h0000);
    idle(1);
  endtask : program_word
endmodule : cwd_prog_model

`default_nettype wire

// ===== tb/cwd_decoder_chk.sv
`timescale 1ns/100ps
`default_nettype none

module cwd_decoder_chk
  import cwd_pkg::*;
#(
  parameter cwd_layout_t LAYOUT = CWD_LAY_STD
) (
  input wire logic clk, // Clock.
  input wire logic resetn, // Reset, active low.
  input wire cwd_cmd_t cmd, // Command.
  input wire logic [13:0] prog_addr_in, // Fetch address.
  input wire logic [13:0] read_data, // Read data.
  input wire logic read_valid, // Read strobe.
  input wire logic [13:0] addr_counter, // Address counter.
  input wire logic programming, // Pulse in progress.
  input wire logic [13:0] config_word, // Word read back.
  input wire logic [13:0] prog_addr_mapped, // Aliased address.
  input wire cwd_settings_t settings // Decoded settings.
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  a_read_answer: assert property (cmd.valid && cmd.code == CWD_CMD_READ_DATA |=> read_valid &&
    read_data == (($past(addr_counter) == CWD_CFG_ADDR) ? $past(config_word) : CWD_ERASED))
    else $error("read answer wrong");
  a_load_cfg_addr: assert property (cmd.valid && cmd.code == CWD_CMD_LOAD_CFG |=>
    addr_counter == CWD_CFG_BASE)
    else $error("load cfg address wrong");
  a_incr_addr: assert property (cmd.valid && cmd.code == CWD_CMD_INCR_ADDR |=>
    addr_counter == $past(addr_counter) + 14'h0001)
    else $error("increment wrong");
  a_prog_start: assert property (cmd.valid && cmd.code == CWD_CMD_BEGIN_PROG |=> programming)
    else $error("programming not started");
  a_prog_end: assert property (cmd.valid && cmd.code == CWD_CMD_END_PROG |=> !programming)
    else $error("programming not ended");
  a_only_clears: assert property ($past(resetn) |-> (config_word & ~$past(config_word)) == 14'h0000)
    else $error("erased bit set again");
  a_brownout_forces_timer: assert property (settings.brownout_reset_enable |-> settings.powerup_timer_on)
    else $error("brown-out without power-up timer");
  a_put_decode: assert property (LAYOUT == CWD_LAY_STD && $past(resetn) |->
    settings.powerup_timer_on == (!$past(config_word[3]) || $past(config_word[6])))
    else $error("power-up timer decode wrong");
  a_copies_agree: assert property (LAYOUT == CWD_LAY_STD && $past(resetn) |-> settings.copies_agree ==
    ($past(config_word[13:12]) == $past(config_word[5:4]) && $past(config_word[11:10]) == $past(config_word[5:4])
    && $past(config_word[9:8]) == $past(config_word[5:4])))
    else $error("copy agreement wrong");
  a_bit7_one: assert property (LAYOUT != CWD_LAY_SINGLE |-> config_word[7])
    else $error("unimplemented bit reads zero");
  a_no_alias: assert property (LAYOUT != CWD_LAY_LOWEND_SM && $past(resetn) |->
    prog_addr_mapped == $past(prog_addr_in))
    else $error("address altered");
endmodule : cwd_decoder_chk

bind cwd_decoder cwd_decoder_chk #(.LAYOUT(LAYOUT)) chk_u (.clk(clk), .resetn(resetn), .cmd(cmd),
  .prog_addr_in(prog_addr_in), .read_data(read_data), .read_valid(read_valid), .addr_counter(addr_counter),
  .programming(programming), .config_word(config_word), .prog_addr_mapped(prog_addr_mapped),
  .settings(settings));

`default_nettype wire

// ===== tb/test_config_word_decoder.sv
`timescale 1ns/100ps
`default_nettype none

module test_config_word_decoder
  import cwd_pkg::*;
;
  logic clk;
  logic resetn;
  cwd_cmd_t cmd;
  logic [13:0] prog_addr_in;
  logic [13:0] read_data;
  logic read_valid;
  logic [13:0] addr_counter;
  logic programming;
  logic [13:0] config_word;
  logic [13:0] prog_addr_mapped;
  cwd_settings_t settings;
  int seed = 14888;
  int fail_count = 0;
  int check_count = 0;
  int word;
  logic [13:0] r;
  cwd_protect_t ptab [4] = '{CWD_PROT_ALL, CWD_PROT_UPPER_3Q, CWD_PROT_UPPER_HALF, CWD_PROT_NONE};
  cwd_osc_t otab [4] = '{CWD_OSC_LP, CWD_OSC_XT, CWD_OSC_HS, CWD_OSC_RC};

  cwd_decoder #(.LAYOUT(CWD_LAY_STD)) dut_u (.clk(clk), .resetn(resetn), .cmd(cmd),
    .prog_addr_in(prog_addr_in), .read_data(read_data), .read_valid(read_valid), .addr_counter(addr_counter),
    .programming(programming), .config_word(config_word), .prog_addr_mapped(prog_addr_mapped),
    .settings(settings));
  cwd_prog_model prog_u (.clk(clk), .cmd(cmd));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic do_reset(input int n);
    resetn = 1'b0;
    repeat (n) begin
      @(posedge clk);
      #10;
    end
    resetn = 1'b1;
    word = 'h3FFF;
  endtask : do_reset

  // Bit 7 is unimplemented in this layout, so the model ORs it in on every read.
  task automatic chk_settings;
    logic [13:0] w;
    logic agree;
    w = word[13:0] | 14'h0080;
    agree = (w[13:12] == w[5:4]) && (w[11:10] == w[5:4]) && (w[9:8] == w[5:4]);
    chk(config_word, w);
    chk(14'(settings.copies_agree), 14'(agree));
    chk(14'(settings.protect), agree ? 14'(ptab[w[5:4]]) : 14'(CWD_PROT_NONE));
    chk(14'(settings.low_block_writable), 14'h0000);
    chk(14'(settings.brownout_reset_enable), 14'(w[6]));
    chk(14'(settings.brownout_trip_voltage), 14'(CWD_TRIP_2V5));
    chk(14'(settings.powerup_timer_on), 14'(!w[3] || w[6]));
    chk(14'(settings.watchdog_enable), 14'(w[2]));
    chk(14'(settings.oscillator_select), 14'(otab[w[1:0]]));
  endtask : chk_settings

  initial begin
    prog_addr_in = 14'h0000;
    do_reset(8);
    prog_u.idle(2);
    chk_settings;
    prog_u.send(CWD_CMD_LOAD_CFG, 14'h0000);
    prog_u.send(6'h3F, 14'h1234);
    chk(addr_counter, CWD_CFG_BASE);
    prog_u.send(CWD_CMD_LOAD_DATA, 14'h1234);
    chk(addr_counter, CWD_CFG_BASE);
    prog_u.send(CWD_CMD_READ_DATA, 14'h0000);
    chk(14'(read_valid), 14'h0001);
    chk(read_data, CWD_ERASED);
    prog_u.send(CWD_CMD_BEGIN_PROG, 14'h0000);
    chk(14'(programming), 14'h0001);
    prog_u.idle(2);
    prog_u.send(CWD_CMD_END_PROG, 14'h0000);
    chk(14'(programming), 14'h0000);
    prog_u.idle(2);
    chk(14'(read_valid), 14'h0000);
    chk_settings;
    for (int i = 0; i < 24; i++) begin
      r = 14'($random(seed));
      if (i < 16) begin
        r[1:0] = i[1:0];
        r[5:4] = i[3:2];
      end
      if (i % 8 != 7) begin
        r[13:12] = r[5:4];
        r[11:10] = r[5:4];
        r[9:8] = r[5:4];
      end
      prog_addr_in = 14'($random(seed));
      prog_u.program_word(r);
      word = word & int'(r);
      if (i > 15 && i[0]) begin
        r = 14'($random(seed));
        prog_u.program_word(r);
        word = word & int'(r);
      end
      prog_u.idle(1);
      chk_settings;
      chk(prog_addr_mapped, prog_addr_in);
      prog_u.send(CWD_CMD_READ_DATA, 14'h0000);
      chk(14'(read_valid), 14'h0001);
      chk(read_data, word[13:0] | 14'h0080);
      prog_u.idle(1);
      do_reset(2);
      chk(config_word, CWD_ERASED);
      prog_u.idle(1);
    end
    end_sim;
  end

  // A full run needs about 530 cycles; ten thousand means a hang.
  initial begin
    #1000000;
    fail_count++;
    end_sim;
  end
endmodule : test_config_word_decoder

`default_nettype wire
